// ### shared/tape_cmd_pkg.sv
/*
 tape_cmd_pkg: constants and carriers for the tape control command port.
 assumes a single 25 MHz core clock; all times are converted to cycles here.
*/
package tape_cmd_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CLK_KHZ = 25000;
   localparam logic [5:0] DEVICE_CODE = 6'h3E;
   localparam int BUS_PULSE_NS = 400;
   localparam int BUS_PULSE_CYCLES = (BUS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CLEAR_DELAY_NS = 5000;
   localparam int CLEAR_DELAY_CYCLES = (CLEAR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLDOFF_NS = 10000;
   localparam int HOLDOFF_CYCLES = (HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TP_NS = 100;
   localparam int TP_CYCLES = (TP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCAL_CLK_KHZ = 120;
   localparam int LOCAL_CLK_CYCLES = CLK_KHZ / LOCAL_CLK_KHZ;
   localparam logic [3:0] FUNC_FORMAT_WRITE = 4'h7;
   localparam logic [9:0] CMD_RESET = 10'h000;
   // accumulator bit positions of the command fields
   localparam int POS_UNIT = 0;
   localparam int POS_DIR = 3;
   localparam int POS_RUN = 4;
   localparam int POS_FUNC = 5;
   localparam int POS_IRQ = 9;

   typedef struct packed {
      logic irq_enable_bit;
      logic [3:0] function_field;
      logic run_bit;
      logic direction_bit;
      logic [2:0] unit_select_bits;
   } cmd_type;

   typedef struct packed {
      logic bus_phase_one;
      logic bus_phase_two;
      logic bus_phase_three;
      logic [5:0] device_field;
      logic [17:0] ac;
   } iot_type;

   typedef struct packed {
      logic forward_motion;
      logic reverse_motion;
      logic go;
      logic stop;
      logic [7:0] drive_select_n;
   } motion_type;
endpackage

// ### src/oneshot_timer.sv
/*
 oneshot_timer: retriggerable one-shot, active for CYCLES clocks after trigger.
 assumes trigger is a single-cycle strobe in the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module oneshot_timer #(
   parameter int unsigned CYCLES = 10
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic trigger,
   output logic active
);
   typedef struct packed {
      logic [15:0] count;
   } os_state_type;
   os_state_type s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (trigger) begin
         s_d.count = 16'(CYCLES);
      end else if (s_q.count != 16'h0000) begin
         s_d.count = s_q.count - 16'h0001;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign active = (s_q.count != 16'h0000);
endmodule
`default_nettype wire

// ### src/unit_decoder.sv
/*
 unit_decoder: three-bit unit number to one-of-eight active-low select.
 assumes the caller registers the result before it leaves the chip.
*/
`timescale 1ns/1ps
`default_nettype none
module unit_decoder (
   input wire logic [2:0] unit,
   output logic [7:0] select_n
);
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_sel
         assign select_n[i] = ~(unit == 3'(i)); // RULE_09
      end
   endgenerate
endmodule
`default_nettype wire

// ### src/tape_control_command_port.sv
/*
 tape_control_command_port: command register, bus pulse decode, motion
 and unit select, and timing pulse generation of the tape controller.
 assumes bus phase strobes, accumulator and tape inputs are synchronous
 to core_clk; each phase strobe is high for at least one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01: clear command on program clear; clear status B on power clear.
// RULE_02: local clock runs only when panel format, run bit and format-write all true.
// RULE_03: divider a toggles per clock rise; divider b toggles per rise of a.
// RULE_04: divider yields alternating 100 ns pulses every 16.6 us.
// RULE_05: while formatting, divider b drives the timing-track write channel.
// RULE_06: write hold sets at counter bit two fall, clears there once enable gone.
// RULE_07: reading derives pulses from timing-track rises when speed_reached, not formatting.
// RULE_08: each data-time pulse opens a 10 us window suppressing further pulses.
// RULE_09: unit bits decode to exactly one of eight active-low selects.
// RULE_10: unit bits load from accumulator bits 00, 01, 02.
// RULE_11: read instruction in phase two gates command fields onto bus 400 ns.
// RULE_12: direction low is forward, high reverse; never both at once.
// RULE_13: both directions off during clear, run low, post-clear delay, buffered run low.
// RULE_14: run set gives go; run clear resets buffered run and gives stop.
// RULE_15: respond only when instruction bits 3-8 hold device code 76 octal.
// RULE_16: clear in phase one makes 400 ns clear pulse and 5 us delay.
// RULE_17: after clear, unit field reads 000.
// RULE_18: delay holds stop and go off; at its end run copies to buffered run.
// RULE_19: load in phase three toggles each bit whose bus input is asserted.
// RULE_20: host asserts bits to toggle 400 us before the load pulse.
// RULE_21: interrupt enable follows accumulator bit 9 and permits interrupt request.
// RULE_22: pulses, delays and divider toggles are strobes and counters, one clock.
module tape_control_command_port
   import tape_cmd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire tape_cmd_pkg::iot_type iot,
   input wire logic program_clear,
   input wire logic power_clear,
   input wire logic panel_format_level,
   input wire logic speed_reached,
   input wire logic timing_track_read,
   input wire logic counter_bit_two,
   input wire logic write_enable_in,
   input wire logic data_active,
   input wire logic device_flag,
   output logic [17:0] bus_out,
   output logic bus_out_valid,
   output logic clear_command_pulse,
   output logic load_command_pulse,
   output logic status_b_clear,
   output logic post_clear_delay,
   output tape_cmd_pkg::cmd_type command_register,
   output tape_cmd_pkg::motion_type motion,
   output logic buffered_run_flop,
   output logic write_word_hold,
   output logic timing_track_write,
   output logic timing_pulse_even,
   output logic timing_pulse_odd,
   output logic irq_request
);
   import tape_cmd_pkg::*;

   typedef struct packed {
      cmd_type cmd;
      logic brun;
      logic [7:0] clk_cnt;
      logic div_a;
      logic div_b;
      logic rd_phase;
      logic track_prev;
      logic c2_prev;
      logic delay_prev;
      logic [1:0] tp_cnt;
      logic tp_odd;
      logic hold;
      logic [17:0] bus_out;
      logic bus_valid;
      logic clr_out;
      logic load_out;
      logic stb_clr;
      logic delay_out;
      motion_type motion;
      logic tt_write;
      logic tp_even_out;
      logic tp_odd_out;
      logic irq;
   } state_type;

   state_type s_q, s_d;

   logic dev_hit;
   logic clr_trig, read_trig, load_trig;
   logic clr_active, read_active, load_active;
   logic delay_active, holdoff_active, tp_fire;
   logic fmt_en;
   logic [7:0] sel_n;

   function automatic logic [17:0] pack_cmd(input cmd_type c);
      logic [17:0] v;
      v = 18'h00000;
      v[POS_UNIT +: 3] = c.unit_select_bits;
      v[POS_DIR] = c.direction_bit;
      v[POS_RUN] = c.run_bit;
      v[POS_FUNC +: 4] = c.function_field;
      v[POS_IRQ] = c.irq_enable_bit;
      return v;
   endfunction

   assign dev_hit = (iot.device_field == DEVICE_CODE); // RULE_15
   // strobes are taken on the rising edge of each phase so a long phase acts once
   logic p1_q, p2_q, p3_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         p1_q <= 1'b0;
         p2_q <= 1'b0;
         p3_q <= 1'b0;
      end else begin
         p1_q <= iot.bus_phase_one;
         p2_q <= iot.bus_phase_two;
         p3_q <= iot.bus_phase_three;
      end
   end
   assign clr_trig = dev_hit & iot.bus_phase_one & ~p1_q; // RULE_16 RULE_22
   assign read_trig = dev_hit & iot.bus_phase_two & ~p2_q; // RULE_11
   assign load_trig = dev_hit & iot.bus_phase_three & ~p3_q; // RULE_19

   oneshot_timer #(.CYCLES(BUS_PULSE_CYCLES)) u_clr_pulse (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .trigger(clr_trig),
      .active(clr_active)
   );
   oneshot_timer #(.CYCLES(BUS_PULSE_CYCLES)) u_read_pulse (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .trigger(read_trig),
      .active(read_active)
   );
   oneshot_timer #(.CYCLES(BUS_PULSE_CYCLES)) u_load_pulse (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .trigger(load_trig),
      .active(load_active)
   );
   oneshot_timer #(.CYCLES(CLEAR_DELAY_CYCLES)) u_clear_delay (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .trigger(clr_trig),
      .active(delay_active)
   );
   oneshot_timer #(.CYCLES(HOLDOFF_CYCLES)) u_holdoff (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .trigger(tp_fire & data_active),
      .active(holdoff_active)
   );

   unit_decoder u_unit_dec (
      .unit(s_q.cmd.unit_select_bits),
      .select_n(sel_n)
   );

   assign fmt_en = panel_format_level & s_q.cmd.run_bit
      & (s_q.cmd.function_field == FUNC_FORMAT_WRITE); // RULE_02

   // the event that would start a timing pulse this cycle
   logic fmt_tick, fmt_rise_a, rd_rise;
   assign fmt_tick = fmt_en & (s_q.clk_cnt == 8'(LOCAL_CLK_CYCLES - 1));
   assign fmt_rise_a = fmt_tick & ~s_q.div_a;
   assign rd_rise = speed_reached & ~panel_format_level
      & timing_track_read & ~s_q.track_prev; // RULE_07
   // crosstalk pulses inside the window are dropped, not delayed
   assign tp_fire = (fmt_rise_a | rd_rise) & ~(holdoff_active & data_active); // RULE_08

   always_comb begin
      s_d = s_q;
      s_d.track_prev = timing_track_read;
      s_d.c2_prev = counter_bit_two;
      s_d.delay_prev = delay_active;

      // command register
      if (program_clear || power_clear || clr_trig) begin
         s_d.cmd = cmd_type'(CMD_RESET); // RULE_01 RULE_17
      end else if (load_trig) begin
         // exclusive-or load; unit bits from 00-02, enable from 09
         s_d.cmd.unit_select_bits = s_q.cmd.unit_select_bits
            ^ iot.ac[POS_UNIT +: 3]; // RULE_10 RULE_19
         s_d.cmd.direction_bit = s_q.cmd.direction_bit ^ iot.ac[POS_DIR];
         s_d.cmd.run_bit = s_q.cmd.run_bit ^ iot.ac[POS_RUN];
         s_d.cmd.function_field = s_q.cmd.function_field
            ^ iot.ac[POS_FUNC +: 4];
         s_d.cmd.irq_enable_bit = s_q.cmd.irq_enable_bit
            ^ iot.ac[POS_IRQ]; // RULE_21
      end

      // buffered run
      if (!s_q.cmd.run_bit) begin
         s_d.brun = 1'b0; // RULE_14
      end else if (s_q.delay_prev && !delay_active) begin
         s_d.brun = s_q.cmd.run_bit; // RULE_18
      end

      // local 120 kc clock and divider
      if (!fmt_en) begin
         s_d.clk_cnt = 8'h00;
      end else if (fmt_tick) begin
         s_d.clk_cnt = 8'h00;
         s_d.div_a = ~s_q.div_a; // RULE_03
         if (!s_q.div_a) begin
            s_d.div_b = ~s_q.div_b; // RULE_03
         end
      end else begin
         s_d.clk_cnt = s_q.clk_cnt + 8'h01; // RULE_22
      end

      // timing pulses: even and odd alternate
      if (s_q.tp_cnt != 2'b00) begin
         s_d.tp_cnt = s_q.tp_cnt - 2'b01;
      end
      if (tp_fire) begin
         s_d.tp_cnt = 2'(TP_CYCLES);
         if (fmt_rise_a) begin
            s_d.tp_odd = s_q.div_b; // RULE_04
         end else begin
            s_d.tp_odd = s_q.rd_phase;
            s_d.rd_phase = ~s_q.rd_phase; // RULE_07
         end
      end
      s_d.tp_even_out = (s_d.tp_cnt != 2'b00) & ~s_d.tp_odd;
      s_d.tp_odd_out = (s_d.tp_cnt != 2'b00) & s_d.tp_odd;

      // write hold changes only at the fall of counter bit two
      if (s_q.c2_prev && !counter_bit_two) begin
         s_d.hold = write_enable_in; // RULE_06
      end

      s_d.tt_write = fmt_en & s_d.div_b; // RULE_05

      // read-back onto the bus
      s_d.bus_valid = read_active | read_trig; // RULE_11
      s_d.bus_out = s_d.bus_valid ? pack_cmd(s_d.cmd) : 18'h00000;

      s_d.clr_out = clr_trig | clr_active; // RULE_16
      s_d.load_out = load_trig | load_active;
      s_d.delay_out = delay_active | clr_trig;
      s_d.stb_clr = power_clear; // RULE_01

      // motion outputs; direction decoded from one bit so never both
      begin
         logic move_ok;
         move_ok = s_d.cmd.run_bit & s_d.brun & ~s_d.delay_out
            & ~s_d.clr_out; // RULE_13
         s_d.motion.forward_motion = move_ok & ~s_d.cmd.direction_bit; // RULE_12
         s_d.motion.reverse_motion = move_ok & s_d.cmd.direction_bit; // RULE_12
      end
      s_d.motion.go = s_d.cmd.run_bit & ~s_d.delay_out; // RULE_14 RULE_18
      s_d.motion.stop = ~s_d.cmd.run_bit & ~s_d.delay_out; // RULE_14 RULE_18
      s_d.motion.drive_select_n = sel_n; // RULE_09

      s_d.irq = s_d.cmd.irq_enable_bit & device_flag; // RULE_21
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.motion.drive_select_n <= 8'hFF;
      end else begin
         s_q <= s_d;
      end
   end

   assign bus_out = s_q.bus_out;
   assign bus_out_valid = s_q.bus_valid;
   assign clear_command_pulse = s_q.clr_out;
   assign load_command_pulse = s_q.load_out;
   assign status_b_clear = s_q.stb_clr;
   assign post_clear_delay = s_q.delay_out;
   assign command_register = s_q.cmd;
   assign motion = s_q.motion;
   assign buffered_run_flop = s_q.brun;
   assign write_word_hold = s_q.hold;
   assign timing_track_write = s_q.tt_write;
   assign timing_pulse_even = s_q.tp_even_out;
   assign timing_pulse_odd = s_q.tp_odd_out;
   assign irq_request = s_q.irq;
endmodule
`default_nettype wire

// ### dv/iot_host_model.sv
/*
 iot_host_model: processor side of the command port, issuing one instruction
 per call in a chosen bus phase. assumes the design samples iot on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module iot_host_model
   import tape_cmd_pkg::*;
#(
   parameter int SETUP_CYCLES = 10000
) (
   input wire logic core_clk,
   input wire logic [17:0] bus_out,
   input wire logic bus_out_valid,
   output var tape_cmd_pkg::iot_type iot
);
   initial iot = '0;
   // the design samples synchronously, so benches shorten the long setup
   task automatic iot_cycle(input int ph, input logic [5:0] code, input logic [17:0] ac, output logic [17:0] rd);
      rd = '0;
      @(posedge core_clk) #1;
      iot.device_field = code;
      iot.ac = ac;
      repeat (SETUP_CYCLES) @(posedge core_clk);
      #1;
      iot.bus_phase_one = (ph == 1);
      iot.bus_phase_two = (ph == 2);
      iot.bus_phase_three = (ph == 3);
      for (int i = 0; i < 14; i++) begin
         @(posedge core_clk) #1;
         if (bus_out_valid === 1'b1 && ph == 2) rd = bus_out;
         if (i == 1) begin
            iot.bus_phase_one = 1'b0;
            iot.bus_phase_two = 1'b0;
            iot.bus_phase_three = 1'b0;
            // released lines show no stale value
            iot.ac = ~ac;
            iot.device_field = ~code;
         end
      end
   endtask
endmodule
`default_nettype wire

// ### dv/tape_cmd_monitor.sv
/*
 tape_cmd_monitor: concurrent checks on the command port outputs.
 assumes one clock domain, core_clk, with async active-low rst_n.
*/
`timescale 1ns/1ps
`default_nettype none
module tape_cmd_monitor
   import tape_cmd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic program_clear,
   input wire logic power_clear,
   input wire logic device_flag,
   input wire logic [17:0] bus_out,
   input wire logic bus_out_valid,
   input wire logic clear_command_pulse,
   input wire logic load_command_pulse,
   input wire logic status_b_clear,
   input wire logic post_clear_delay,
   input wire tape_cmd_pkg::cmd_type command_register,
   input wire tape_cmd_pkg::motion_type motion,
   input wire logic buffered_run_flop,
   input wire logic irq_request
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   dir_exclusive_a: assert property (!(motion.forward_motion && motion.reverse_motion))
      else $error("both directions active");
   dir_follow_a: assert property ($stable(command_register.direction_bit) && (motion.forward_motion || motion.reverse_motion) |-> motion.forward_motion == !command_register.direction_bit)
      else $error("direction mismatch");
   one_select_a: assert property ($past(rst_n) && $stable(command_register.unit_select_bits) |-> motion.drive_select_n == ~(8'h01 << command_register.unit_select_bits))
      else $error("drive select mismatch");
   clear_width_a: assert property ($rose(clear_command_pulse) |-> clear_command_pulse[*8] ##4 !clear_command_pulse)
      else $error("clear pulse width");
   load_width_a: assert property ($rose(load_command_pulse) |-> load_command_pulse[*8] ##4 !load_command_pulse)
      else $error("load pulse width");
   delay_len_a: assert property ($rose(post_clear_delay) |-> ##125 post_clear_delay ##1 !post_clear_delay)
      else $error("post clear delay length");
   delay_quiet_a: assert property (post_clear_delay && $past(post_clear_delay) |-> !motion.go && !motion.stop)
      else $error("stop or go during delay");
   brun_copy_a: assert property ($fell(post_clear_delay) |-> ##[1:2] buffered_run_flop == command_register.run_bit)
      else $error("buffered run not copied");
   motion_gate_a: assert property (!command_register.run_bit || !buffered_run_flop || post_clear_delay |-> !motion.forward_motion && !motion.reverse_motion)
      else $error("motion not inhibited");
   read_bus_a: assert property (bus_out == (bus_out_valid ? {8'h00, command_register} : 18'h00000))
      else $error("read data mismatch");
   irq_follow_a: assert property ($stable(command_register.irq_enable_bit) && $stable(device_flag) |-> irq_request == (command_register.irq_enable_bit && device_flag))
      else $error("interrupt request mismatch");
   status_b_a: assert property (power_clear |=> status_b_clear)
      else $error("status b not cleared");
   prog_clear_a: assert property (program_clear |-> ##[1:2] command_register == CMD_RESET)
      else $error("program clear ignored");
   clear_seen_c: cover property ($rose(clear_command_pulse));
   fwd_seen_c: cover property (motion.forward_motion);
   read_seen_c: cover property ($rose(bus_out_valid));
endmodule
bind tape_control_command_port tape_cmd_monitor mon (.*);
`default_nettype wire

// ### dv/tb_top.sv
/*
 tb_top: self-checking bench for tape_control_command_port.
 assumes iot_host_model issues instructions and the monitor is bound.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tape_cmd_pkg::*;
   logic core_clk, rst_n, program_clear, power_clear, speed_reached, timing_track_read;
   logic counter_bit_two, write_enable_in, device_flag, bus_out_valid, status_b_clear, post_clear_delay;
   logic buffered_run_flop, write_word_hold, timing_pulse_even, timing_pulse_odd, irq_request;
   logic panel_format_level, data_active, timing_track_write, tw;
   logic [7:0] sel_exp;
   logic [17:0] bus_out, rd, cur;
   logic [1:0] tp;
   iot_type iot;
   cmd_type command_register;
   motion_type motion;
   int n_fail = 0;
   int comparisons = 0;
   iot_host_model #(.SETUP_CYCLES(2)) host (.core_clk(core_clk), .bus_out(bus_out),
      .bus_out_valid(bus_out_valid), .iot(iot));
   tape_control_command_port DUT (.core_clk(core_clk), .rst_n(rst_n), .iot(iot),
      .program_clear(program_clear), .power_clear(power_clear), .panel_format_level(panel_format_level),
      .speed_reached(speed_reached), .timing_track_read(timing_track_read),
      .counter_bit_two(counter_bit_two), .write_enable_in(write_enable_in), .data_active(data_active),
      .device_flag(device_flag), .bus_out(bus_out), .bus_out_valid(bus_out_valid),
      .clear_command_pulse(), .load_command_pulse(), .status_b_clear(status_b_clear),
      .post_clear_delay(post_clear_delay), .command_register(command_register), .motion(motion),
      .buffered_run_flop(buffered_run_flop), .write_word_hold(write_word_hold),
      .timing_track_write(timing_track_write), .timing_pulse_even(timing_pulse_even),
      .timing_pulse_odd(timing_pulse_odd), .irq_request(irq_request));
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic op(input int ph, input logic [17:0] ac);
      host.iot_cycle(ph, 6'h3E, ac, rd);
   endtask
   function automatic logic [17:0] mot();
      return 18'({motion.forward_motion, motion.reverse_motion, motion.go, motion.stop});
   endfunction
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // far longer than the roughly 1600 cycles the sequence needs
   initial begin
      #400000;
      n_fail++;
      finish_test();
   end
   initial begin
      {rst_n, program_clear, power_clear, speed_reached, timing_track_read} = '0;
      {counter_bit_two, write_enable_in, device_flag, panel_format_level, data_active} = '0;
      repeat (2) @(posedge core_clk);
      #1 rst_n = 1'b1;
      @(posedge core_clk) #1;
      check(18'(command_register), 18'h0);
      check(18'(motion.drive_select_n), 18'hFE);
      cur = '0;
      for (int u = 0; u < 8; u++) begin
         op(3, 18'(u) ^ cur);
         cur = 18'(u);
         op(2, 18'h0);
         check(rd, cur);
         sel_exp = ~(8'h01 << u);
         check(18'(motion.drive_select_n), 18'(sel_exp));
      end
      host.iot_cycle(3, 6'h3D, 18'h3FF, rd);
      check(18'(command_register), cur);
      op(3, 18'h3FFE0);
      cur = cur ^ 18'h3E0;
      check(18'(command_register), cur);
      device_flag = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 check(18'(irq_request), 18'h1);
      op(1, 18'h0);
      check(18'(command_register), 18'h0);
      check(18'(post_clear_delay), 18'h1);
      op(3, 18'h010);
      check(mot(), 18'h0);
      repeat (130) @(posedge core_clk);
      #1 check(18'(buffered_run_flop), 18'h1);
      check(mot(), 18'hA);
      op(3, 18'h008);
      check(mot(), 18'h6);
      op(3, 18'h010);
      check(mot(), 18'h1);
      check(18'(buffered_run_flop), 18'h0);
      op(3, 18'h007);
      program_clear = 1'b1;
      @(posedge core_clk) #1 program_clear = 1'b0;
      power_clear = 1'b1;
      @(posedge core_clk) #1 check(18'(status_b_clear), 18'h1);
      power_clear = 1'b0;
      check(18'(command_register), 18'h0);
      speed_reached = 1'b1;
      for (int k = 0; k < 2; k++) begin
         tp = '0;
         timing_track_read = 1'b1;
         for (int i = 0; i < 6; i++) begin
            @(posedge core_clk) #1 tp = tp | {timing_pulse_even, timing_pulse_odd};
         end
         timing_track_read = 1'b0;
         repeat (4) @(posedge core_clk);
         #1 check(18'(tp), (k == 0) ? 18'h2 : 18'h1);
      end
      write_enable_in = 1'b1;
      counter_bit_two = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 counter_bit_two = 1'b0;
      repeat (3) @(posedge core_clk);
      #1 check(18'(write_word_hold), 18'h1);
      write_enable_in = 1'b0;
      counter_bit_two = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 counter_bit_two = 1'b0;
      repeat (3) @(posedge core_clk);
      #1 check(18'(write_word_hold), 18'h0);
      // the second rise lands inside the crosstalk window and is dropped
      data_active = 1'b1;
      for (int k = 0; k < 3; k++) begin
         tp = '0;
         timing_track_read = 1'b1;
         for (int i = 0; i < 6; i++) begin
            @(posedge core_clk) #1 tp = tp | {timing_pulse_even, timing_pulse_odd};
         end
         timing_track_read = 1'b0;
         repeat ((k == 1) ? 300 : 4) @(posedge core_clk);
         #1 check(18'(tp), (k == 0) ? 18'h2 : ((k == 1) ? 18'h0 : 18'h1));
      end
      data_active = 1'b0;
      panel_format_level = 1'b1;
      op(3, 18'h0F0);
      tp = '0;
      tw = 1'b0;
      for (int i = 0; i < 700; i++) begin
         @(posedge core_clk) #1 tp = tp | {timing_pulse_even, timing_pulse_odd};
         tw = tw | timing_track_write;
      end
      check(18'(tp), 18'h3);
      check(18'(tw), 18'h1);
      finish_test();
   end
endmodule
`default_nettype wire
